// File: hw/ldr_pkg.sv
package ldr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RAMP_TIMES = 8'h94;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h95;
    localparam logic [7:0] RAMP_TIMES_RESET = 8'h00;
    localparam logic [7:0] OFF_DELAY_RESET = 8'h00;
    // Bits that exist; the rest are reserved and read as zero
    localparam logic [7:0] RAMP_TIMES_MASK = 8'h3f;
    localparam logic [7:0] OFF_DELAY_MASK = 8'h7f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RISE_LSB = 3;
    localparam int FALL_LSB = 0;
    localparam int GAP_LSB = 4;
    localparam int HOLD_LSB = 0;
    localparam int PEAK_LSB = 4;
    localparam int FLOOR_LSB = 0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PWM_STEP_NS = 5000;
    localparam int PWM_STEP_CYCLES =
        (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWM_FULL_SCALE = 100;
    localparam int STEP_MS = 250;
    localparam int LONG_CODE_MS = 2000;
    localparam int HOLD_COARSE_MS = 500;
    localparam int HOLD_MAX_MS = 5000;
    localparam int BREATHE_LSB_MS = 32;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [12:0] ldr_ms_t;
    typedef logic [6:0] ldr_pct_t;
    typedef enum logic [2:0] {
        ST_FLOOR, ST_RISE, ST_PEAK, ST_HOLD, ST_FALL, ST_GAP
    } ldr_state_t;
    typedef enum logic {MODE_DIRECT, MODE_BREATHE} ldr_mode_t;

    // ----------------------------------------------------------------
    // Duty decode in percent
    // ----------------------------------------------------------------
    localparam ldr_pct_t PEAK_TABLE [16] = '{
        7'h07, 7'h09, 7'h0b, 7'h0e, 7'h11, 7'h14, 7'h17, 7'h1a,
        7'h1e, 7'h23, 7'h28, 7'h2e, 7'h35, 7'h3f, 7'h4d, 7'h64};
    localparam ldr_pct_t FLOOR_TABLE [16] = '{
        7'h00, 7'h07, 7'h09, 7'h0b, 7'h0e, 7'h11, 7'h14, 7'h17,
        7'h1a, 7'h1e, 7'h23, 7'h28, 7'h2e, 7'h35, 7'h3f, 7'h4d};

    // Three-bit ramp or gap code to milliseconds
    function automatic ldr_ms_t ramp_ms(input logic [2:0] code);
        if (code == 3'h7) begin
            ramp_ms = ldr_ms_t'(LONG_CODE_MS);
        end else begin
            ramp_ms = ldr_ms_t'(code) * ldr_ms_t'(STEP_MS);
        end
    endfunction

    // Four-bit hold code to milliseconds
    function automatic ldr_ms_t hold_ms(input logic [3:0] code);
        if (code <= 4'h7) begin
            hold_ms = ldr_ms_t'(code) * ldr_ms_t'(STEP_MS);
        end else if (code <= 4'hc) begin
            hold_ms = ldr_ms_t'(LONG_CODE_MS)
                + ldr_ms_t'(code - 4'h7) * ldr_ms_t'(HOLD_COARSE_MS);
        end else begin
            hold_ms = ldr_ms_t'(HOLD_MAX_MS);
        end
    endfunction

endpackage

// File: hw/ldr_pwm.sv
module ldr_pwm
    import ldr_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Enables
    ldr_tick_if.sink ticks,
    // Duty
    input wire ldr_pct_t level_in,
    output logic pwm_on_out
);

    ldr_pct_t phase;

    // ----------------------------------------------------------------
    // Counter over one PWM frame of 100 steps
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            phase <= 7'h0;
        end else if (ticks.pwm_step) begin
            if (phase == 7'(PWM_FULL_SCALE - 1)) begin
                phase <= 7'h0;
            end else begin
                phase <= phase + 7'h1;
            end
        end
    end

    // Full scale keeps the output high for the whole frame
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pwm_on_out <= 1'b0;
        end else begin
            pwm_on_out <= (phase < level_in);
        end
    end

endmodule

// File: hw/ldr_tick_gen.sv
module ldr_tick_gen
    import ldr_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Enables
    ldr_tick_if.gen ticks
);

    logic [16:0] ms_count;
    logic [8:0] step_count;

    // ----------------------------------------------------------------
    // Millisecond tick: 250 ms is a whole number of these, so no drift
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ms_count <= 17'h0;
            ticks.tick_ms <= 1'b0;
        end else if (ms_count == 17'(TICKS - 1)) begin
            ms_count <= 17'h0;
            ticks.tick_ms <= 1'b1;
        end else begin
            ms_count <= ms_count + 17'h1;
            ticks.tick_ms <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // PWM step enable
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            step_count <= 9'h0;
            ticks.pwm_step <= 1'b0;
        end else if (step_count == 9'(PWM_STEP_CYCLES - 1)) begin
            step_count <= 9'h0;
            ticks.pwm_step <= 1'b1;
        end else begin
            step_count <= step_count + 9'h1;
            ticks.pwm_step <= 1'b0;
        end
    end

endmodule

// File: hw/ldr_tick_if.sv
interface ldr_tick_if;
    logic tick_ms;
    logic pwm_step;
    modport gen (output tick_ms, output pwm_step);
    modport sink (input tick_ms, input pwm_step);
endinterface

// File: hw/ldr_top.sv
// Overview of operation
// - Rise code sets zero to two second ramp
// - Fall code uses the same time decode
// - Rise moves duty from floor to peak
// - Fall moves duty from peak to floor
// - Rise and fall codes affect Direct only
// - Hold keeps duty where unactuation left it before falling
// - Breathe waits selected gap after each breath
// - Unactuation in Direct starts hold, then falling ramp
// - Four-bit hold code up to five seconds
// - Output combines times, duties, hold and polarity
// - Polarity one normal, zero inverted output
// - Direct duties live, Breathe duties latched
// - Peak upper nibble, floor lower, table decoded
module ldr_top
    import ldr_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // LED control from the rest of the device
    input wire logic actuate_in,
    input wire logic breathe_mode_in,
    input wire logic led_polarity_select_in,
    input wire logic [7:0] direct_duty_in,
    input wire logic [7:0] breathe_duty_in,
    input wire logic [6:0] breathe_period_in,
    // LED drive and status
    output logic led_pwm_out,
    output ldr_pct_t duty_level_out,
    output logic ramp_busy_out
);

    logic [7:0] ramp_times, off_delay;
    ldr_state_t state;
    ldr_mode_t mode_l;
    ldr_pct_t level, br_peak_l, br_floor_l, peak_now, floor_now;
    ldr_pct_t span, entry_floor;
    ldr_ms_t timer, acc, next_acc, ramp_len, br_half_ms;
    ldr_ms_t rise_ms, fall_ms, gap_ms, dly_ms;
    logic [6:0] br_period_l;
    logic pwm_on, ramp_done, step_due;

    ldr_tick_if ticks ();

    ldr_tick_gen #(.TICKS(TICKS)) u_ticks (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ticks(ticks.gen)
    );

    ldr_pwm u_pwm (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ticks(ticks.sink),
        .level_in(level),
        .pwm_on_out(pwm_on)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ramp_times <= RAMP_TIMES_RESET;
            off_delay <= OFF_DELAY_RESET;
        end else if (reg_wr_in) begin
            if (reg_addr_in == ADDR_RAMP_TIMES) begin
                ramp_times <= reg_wdata_in & RAMP_TIMES_MASK;
            end
            if (reg_addr_in == ADDR_OFF_DELAY) begin
                off_delay <= reg_wdata_in & OFF_DELAY_MASK;
            end
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_RAMP_TIMES: reg_rdata_out <= ramp_times;
                ADDR_OFF_DELAY: reg_rdata_out <= off_delay;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Decode of times and duties
    // ----------------------------------------------------------------
    always_comb begin
        rise_ms = ramp_ms(ramp_times[RISE_LSB +: 3]);
        fall_ms = ramp_ms(ramp_times[FALL_LSB +: 3]);
        gap_ms = ramp_ms(off_delay[GAP_LSB +: 3]);
        dly_ms = hold_ms(off_delay[HOLD_LSB +: 4]);
        br_half_ms = ldr_ms_t'(br_period_l)
            * ldr_ms_t'(BREATHE_LSB_MS / 2);
        if (mode_l == MODE_BREATHE) begin
            peak_now = br_peak_l;
            floor_now = br_floor_l;
        end else begin
            peak_now = PEAK_TABLE[direct_duty_in[PEAK_LSB +: 4]];
            floor_now = FLOOR_TABLE[direct_duty_in[FLOOR_LSB +: 4]];
        end
        entry_floor = breathe_mode_in
            ? FLOOR_TABLE[breathe_duty_in[FLOOR_LSB +: 4]] : floor_now;
        // A crossed setting gives a flat ramp instead of a wrap
        span = (peak_now > floor_now) ? peak_now - floor_now : 7'h0;
    end

    // Ramp length depends on the behaviour: codes only steer Direct
    always_comb begin
        if (mode_l == MODE_BREATHE) begin
            ramp_len = br_half_ms;
        end else if (state == ST_FALL) begin
            ramp_len = fall_ms;
        end else begin
            ramp_len = rise_ms;
        end
        // Spread span steps evenly over ramp_len milliseconds
        next_acc = acc + ldr_ms_t'(span);
        step_due = ticks.tick_ms && (next_acc >= ramp_len);
        ramp_done = (ramp_len == 13'h0)
            || (ticks.tick_ms && (timer + 13'h1 >= ramp_len));
    end

    // ----------------------------------------------------------------
    // Breathe settings are loaded every cycle in ST_FLOOR and held from actuation
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mode_l <= MODE_DIRECT;
            br_peak_l <= 7'h0;
            br_floor_l <= 7'h0;
            br_period_l <= 7'h0;
        end else if (state == ST_FLOOR) begin
            mode_l <= breathe_mode_in ? MODE_BREATHE : MODE_DIRECT;
            br_peak_l <= PEAK_TABLE[breathe_duty_in[PEAK_LSB +: 4]];
            br_floor_l <= FLOOR_TABLE[breathe_duty_in[FLOOR_LSB +: 4]];
            br_period_l <= breathe_period_in;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= ST_FLOOR;
            level <= 7'h0;
            timer <= 13'h0;
            acc <= 13'h0;
        end else begin
            case (state)
                ST_FLOOR: begin
                    level <= (mode_l == MODE_DIRECT) ? floor_now : 7'h0;
                    timer <= 13'h0;
                    acc <= 13'h0;
                    if (actuate_in) begin
                        state <= ST_RISE;
                        level <= entry_floor;
                    end
                end
                ST_RISE: begin
                    if (!actuate_in) begin
                        timer <= 13'h0;
                        state <= (mode_l == MODE_DIRECT) ? ST_HOLD
                            : ST_FLOOR;
                    end else if (ramp_done) begin
                        level <= peak_now;
                        timer <= 13'h0;
                        acc <= 13'h0;
                        state <= (mode_l == MODE_DIRECT) ? ST_PEAK
                            : ST_FALL;
                    end else if (ticks.tick_ms) begin
                        timer <= timer + 13'h1;
                        if (step_due) begin
                            acc <= next_acc - ramp_len;
                            if (level < peak_now) begin
                                level <= level + 7'h1;
                            end
                        end else begin
                            acc <= next_acc;
                        end
                    end
                end
                ST_PEAK: begin
                    if (!actuate_in) begin
                        timer <= 13'h0;
                        state <= ST_HOLD;
                    end else begin
                        level <= peak_now;
                    end
                end
                ST_HOLD: begin
                    if (actuate_in) begin
                        timer <= 13'h0;
                        acc <= 13'h0;
                        state <= ST_RISE;
                    end else if (dly_ms == 13'h0 || (ticks.tick_ms
                            && timer + 13'h1 >= dly_ms)) begin
                        timer <= 13'h0;
                        acc <= 13'h0;
                        state <= ST_FALL;
                    end else if (ticks.tick_ms) begin
                        timer <= timer + 13'h1;
                    end
                end
                ST_FALL: begin
                    if (actuate_in == (mode_l == MODE_DIRECT)) begin
                        timer <= 13'h0;
                        acc <= 13'h0;
                        state <= (mode_l == MODE_DIRECT) ? ST_RISE
                            : ST_FLOOR;
                    end else if (ramp_done) begin
                        timer <= 13'h0;
                        level <= (mode_l == MODE_DIRECT) ? floor_now
                            : 7'h0;
                        state <= (mode_l == MODE_DIRECT) ? ST_FLOOR
                            : ST_GAP;
                    end else if (ticks.tick_ms) begin
                        timer <= timer + 13'h1;
                        if (step_due) begin
                            acc <= next_acc - ramp_len;
                            if (level > floor_now) begin
                                level <= level - 7'h1;
                            end
                        end else begin
                            acc <= next_acc;
                        end
                    end
                end
                ST_GAP: begin
                    if (!actuate_in) begin
                        state <= ST_FLOOR;
                    end else if (gap_ms == 13'h0 || (ticks.tick_ms
                            && timer + 13'h1 >= gap_ms)) begin
                        timer <= 13'h0;
                        acc <= 13'h0;
                        level <= floor_now;
                        state <= ST_RISE;
                    end else if (ticks.tick_ms) begin
                        timer <= timer + 13'h1;
                    end
                end
                default: begin
                    state <= ST_FLOOR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            led_pwm_out <= 1'b0;
            duty_level_out <= 7'h0;
            ramp_busy_out <= 1'b0;
        end else begin
            led_pwm_out <= led_polarity_select_in ? pwm_on
                : !pwm_on;
            duty_level_out <= level;
            ramp_busy_out <= (state != ST_FLOOR);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sequence s_rise_to_peak;
        state == ST_RISE && mode_l == MODE_DIRECT ##1 state == ST_PEAK;
    endsequence
    sequence s_fall_to_floor;
        state == ST_FALL && mode_l == MODE_DIRECT ##1 state == ST_FLOOR;
    endsequence
    sequence s_unact_at_peak;
        mode_l == MODE_DIRECT && state == ST_PEAK && !actuate_in;
    endsequence
    // Code sampled one cycle late: a write there still steers the ramp
    chk_zero_rise_time: assert property (
        state == ST_FLOOR && actuate_in && !breathe_mode_in
            ##1 actuate_in && ramp_times[RISE_LSB +: 3] == 3'h0
        |-> state == ST_RISE ##1 state == ST_PEAK)
        else $error("zero rise code did not reach peak at once");
    chk_zero_fall_time: assert property (
        state == ST_HOLD && mode_l == MODE_DIRECT && !actuate_in
            && dly_ms == 13'h0
            ##1 !actuate_in && ramp_times[FALL_LSB +: 3] == 3'h0
        |-> state == ST_FALL ##1 state == ST_FLOOR)
        else $error("zero fall code did not reach floor at once");
    chk_rise_ends_peak: assert property (
        s_rise_to_peak |-> level == $past(peak_now))
        else $error("rise did not end at peak duty");
    chk_fall_ends_floor: assert property (
        s_fall_to_floor |-> level == $past(floor_now))
        else $error("fall did not end at floor duty");
    chk_hold_level_kept: assert property (
        state == ST_HOLD && $past(state) == ST_HOLD |-> $stable(level))
        else $error("duty moved during hold");
    chk_unact_starts_hold: assert property (
        s_unact_at_peak |=> state == ST_HOLD && timer == 13'h0)
        else $error("unactuation did not start the hold");
    // A zero hold still spends one cycle in the hold state
    chk_hold_time_limit: assert property (
        state == ST_HOLD && dly_ms != 13'h0 |-> timer < dly_ms)
        else $error("hold ran past its programmed time");
    chk_gap_dark: assert property (
        state == ST_GAP |-> level == 7'h0)
        else $error("breathe gap not inactive");
    chk_polarity_out: assert property (
        1'b1 |=> led_pwm_out == ($past(led_polarity_select_in)
            ? $past(pwm_on) : !$past(pwm_on)))
        else $error("polarity not applied to output");
    chk_breathe_latched: assert property (
        mode_l == MODE_BREATHE && state != ST_FLOOR
            && $past(state) != ST_FLOOR
        |-> $stable(br_peak_l) && $stable(br_period_l))
        else $error("breathe settings changed while actuated");
    chk_direct_live: assert property (
        mode_l == MODE_DIRECT && state == ST_PEAK
            && $past(state) == ST_PEAK && $past(actuate_in)
        |-> level == $past(peak_now))
        else $error("direct peak not applied at once");
endmodule

// File: tb/ldr_led_model.sv
// ----------------------------------------------------------------
// LED on the drive pin: lit while the pin is driven high
// ----------------------------------------------------------------
module ldr_led_model (
    // Clock
    input wire logic clock_in,
    // Pin
    input wire logic drive_in,
    // Lit cycles seen so far
    output int lit_out
);
    timeunit 1ns;
    timeprecision 1ns;

    int lit_count = 0;

    assign lit_out = lit_count;

    // An unknown drive never counts as lit
    always @(posedge clock_in) begin
        if (drive_in === 1'b1) begin
            lit_count <= lit_count + 1;
        end
    end
endmodule

// File: tb/testbench.sv
module testbench
    import ldr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Short tick keeps every time in the run small
    localparam int T = 10;

    logic clock_in, rst_in, wr, rd, act, brm, pol, pwm, busy;
    logic [7:0] addr, wdata, rdata, dduty, bduty;
    logic [6:0] bper;
    ldr_pct_t lvl;
    int lit;
    int n_fail = 0;
    int checks = 0;

    ldr_top #(.TICKS(T)) u_ldr_top (
        .clock_in(clock_in), .rst_in(rst_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .actuate_in(act), .breathe_mode_in(brm),
        .led_polarity_select_in(pol), .direct_duty_in(dduty),
        .breathe_duty_in(bduty), .breathe_period_in(bper),
        .led_pwm_out(pwm), .duty_level_out(lvl), .ramp_busy_out(busy)
    );

    ldr_led_model u_ldr_led_model (
        .clock_in(clock_in), .drive_in(pwm), .lit_out(lit)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clock_in);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        rd = 1'b1;
        addr = a;
        @(negedge clock_in);
        rd = 1'b0;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask

    // Waits while the level test differs from eq; bounded by hi
    task automatic wait_lvl(input string what, input ldr_pct_t v,
                            input bit eq, input int lo, input int hi);
        int n;
        n = 0;
        while (((lvl === v) != eq) && n < hi) begin
            @(negedge clock_in);
            n++;
        end
        checks++;
        if (n < lo || n >= hi) begin
            n_fail++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
        if (n >= hi) test_done();
    endtask

    task automatic lit_chk(input string what, input logic [7:0] exp);
        int a;
        repeat (3) @(negedge clock_in);
        a = lit;
        repeat (200) @(negedge clock_in);
        chk(what, exp, 8'(lit - a));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd_chk(8'h94, 8'h00);
        rd_chk(8'h95, 8'h00);
        wr_reg(8'h94, 8'hff);
        wr_reg(8'h95, 8'hff);
        rd_chk(8'h94, 8'h3f);
        rd_chk(8'h95, 8'h7f);
        rd_chk(8'h96, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_direct;
        wr_reg(8'h94, 8'h0a);
        wr_reg(8'h95, 8'h11);
        dduty = 8'h93;
        repeat (4) @(negedge clock_in);
        chk("idle floor", 8'h0b, 8'(lvl));
        dduty = 8'hf0;
        repeat (4) @(negedge clock_in);
        chk("live floor", 8'h00, 8'(lvl));
        act = 1'b1;
        wait_lvl("rise", 7'h64, 1'b1, 240 * T, 260 * T);
        lit_chk("lit normal", 8'hc8);
        pol = 1'b0;
        lit_chk("lit inverted", 8'h00);
        pol = 1'b1;
        act = 1'b0;
        wait_lvl("hold", 7'h64, 1'b0, 240 * T, 260 * T);
        wait_lvl("fall", 7'h00, 1'b1, 480 * T, 510 * T);
        $display("test direct done");
    endtask

    task automatic t_breathe;
        // Slow ramp codes must not touch a breath
        wr_reg(8'h94, 8'h3f);
        brm = 1'b1;
        bduty = 8'hf0;
        bper = 7'h02;
        repeat (4) @(negedge clock_in);
        act = 1'b1;
        wait_lvl("breath up", 7'h64, 1'b1, 0, 40 * T);
        wait_lvl("breath down", 7'h00, 1'b1, 28 * T, 40 * T);
        wait_lvl("breath gap", 7'h00, 1'b0, 245 * T, 260 * T);
        act = 1'b0;
        wait_lvl("breath idle", 7'h00, 1'b1, 0, 300 * T);
        repeat (4) @(negedge clock_in);
        chk("busy idle", 8'h00, {7'h00, busy});
        brm = 1'b0;
        $display("test breathe done");
    endtask

    // Zero codes: peak and floor within a few cycles, peak stays live
    task automatic t_zero;
        wr_reg(8'h94, 8'h00);
        wr_reg(8'h95, 8'h00);
        act = 1'b1;
        wait_lvl("zero rise", 7'h64, 1'b1, 0, 6);
        chk("busy high", 8'h01, {7'h00, busy});
        dduty = 8'he0;
        repeat (3) @(negedge clock_in);
        chk("live peak", 8'h4d, 8'(lvl));
        dduty = 8'hf0;
        act = 1'b0;
        wait_lvl("zero fall", 7'h00, 1'b1, 0, 6);
        $display("test zero done");
    endtask

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    initial begin
        rst_in = 1'b1;
        {wr, rd, act, brm} = 4'h0;
        pol = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        dduty = 8'hf0;
        bduty = 8'hf0;
        bper = 7'h02;
        repeat (12) @(negedge clock_in);
        rst_in = 1'b0;
        t_regs();
        t_direct();
        t_breathe();
        t_zero();
        test_done();
    end
endmodule
